/* File: logic/tcc_call_control.sv */
// Purpose: Call-control sequencer for a start-stop printer on a switched loop.
// Assumes: Loop comparators and buttons are asynchronous; Wishbone on sys_clk.
// Notes:   Outputs are all flip-flops; the dialer is started by a register write.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

// What this block does
// - Dialer sends ten pulses per second, contacts open 0.061 s plus or minus 0.003.
// - While the dialer runs the selector sees steady mark.
// - Idle: motor stopped, lamps dark, loop carries small positive current.
// - Originate button shunts loop resistance raising current; operator holds it.
// - Short exchange interruption lights proceed lamp and latches the shunt.
// - Each dial pulse is no current 0.06 s then full current 0.04 s.
// - Reversal to negative after dialing starts motor and lights connected lamp.
// - Connected: mark is full current, space is zero current.
// - Busy reversal then positive: brief connect, back to idle on positive.
// - Idle reversal to negative: connected lamp, motor, shunt applied.
// - Release button opens loop; exchange positive return then ends the call.
// - Far-end disconnect returns idle exactly as local disconnect.
// - Holding the offline button until the local lamp lights enters local mode.
// - Release held leaves local mode; originate starts a call directly.
// - Incoming call in local mode sounds buzzer 2.6 s then connects.
// - Proceed, connect and local latches have delayed feedback: 1 ms, 20 ms.
// - Line inputs are filtered so noise does not change call state.
// - Magnet driver outputs full mark or none, deciding at half current.
// - Motor turn-off delayed 0.475 to 0.675 s after stop.
module tcc_call_control #(
  parameter int FILT_CYC = tcc_pkg::T_FILT_US * tcc_pkg::CLK_MHZ,
  parameter int CONNECTED_LAMP_CYC = tcc_pkg::T_CONNECTED_LAMP_US * tcc_pkg::CLK_MHZ,
  parameter int LOCL_CYC = tcc_pkg::T_LOCAL_US * tcc_pkg::CLK_MHZ,
  parameter int PMIN_CYC = tcc_pkg::T_PTD_MIN_US * tcc_pkg::CLK_MHZ,
  parameter int PMAX_CYC = tcc_pkg::T_PTD_MAX_US * tcc_pkg::CLK_MHZ,
  parameter int DOPN_CYC = tcc_pkg::T_DIAL_OPN_US * tcc_pkg::CLK_MHZ,
  parameter int DPER_CYC = tcc_pkg::T_DIAL_PER_US * tcc_pkg::CLK_MHZ,
  parameter int RING_CYC = tcc_pkg::T_RING_US * tcc_pkg::CLK_MHZ,
  parameter int MOTR_CYC = tcc_pkg::T_MOTOR_US * tcc_pkg::CLK_MHZ
) (
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  input  wire logic        line_pos,
  input  wire logic        line_neg,
  input  wire logic        line_half,
  input  wire logic        tx_mark,
  input  wire logic        originate_button,
  input  wire logic        release_button,
  input  wire logic        offline_button,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  output logic             loop_shunt,
  output logic             loop_open,
  output logic             dial_lamp,
  output logic             connected_lamp,
  output logic             local_lamp,
  output logic             buzzer,
  output logic             motor_on,
  output logic             magnet_amplifier
);

  typedef struct packed {
    logic [6:0]           s1;
    logic [6:0]           s2;
    tcc_pkg::tcc_line_e   cand;
    logic [13:0]          fcnt;
    tcc_pkg::tcc_line_e   cls;
    tcc_pkg::tcc_state_e  st;
    logic [24:0]          tcnt;
    logic [17:0]          hcnt;
    logic [3:0]           dleft;
    logic [19:0]          dcnt;
    logic                 dial_open;
    logic [22:0]          mcnt;
    logic                 motor;
    logic                 shunt;
    logic                 lopen;
    logic                 dlamp;
    logic                 clamp;
    logic                 llamp;
    logic                 buzz;
    logic                 magnet;
    logic                 ack;
    logic [31:0]          dat;
  } tcc_regs_s;

  tcc_regs_s q;
  tcc_regs_s n;

  always_comb begin
    tcc_pkg::tcc_line_e raw;
    logic               cond;
    logic               hold;
    logic               mcmd;
    logic               req;
    logic [3:0]         digit;
    n = q;
    raw = tcc_pkg::LN_OPEN;
    cond = 1'b0;
    hold = 1'b0;
    mcmd = 1'b0;
    req = 1'b0;
    digit = 4'h0;
    n.s1 = {offline_button, release_button, originate_button, tx_mark, line_half, line_neg, line_pos};
    n.s2 = q.s1;

    if (q.s2[tcc_pkg::IN_NEG] && !q.s2[tcc_pkg::IN_POS]) begin
      raw = tcc_pkg::LN_NEG;
    end else if (q.s2[tcc_pkg::IN_POS] && !q.s2[tcc_pkg::IN_NEG]) begin
      raw = tcc_pkg::LN_POS;
    end
    // a class must persist for the filter time before it counts.
    // interruptions shorter than this never reach the sequencer.
    if (raw != q.cand) begin
      n.cand = raw;
      n.fcnt = 14'h0;
    end else if (q.fcnt == 14'(FILT_CYC - 1)) begin
      n.cls = q.cand;
    end else begin
      n.fcnt = q.fcnt + 14'h1;
    end

    unique case (q.st)
      tcc_pkg::ST_ORIG:  cond = (q.cls == tcc_pkg::LN_OPEN);
      tcc_pkg::ST_CONNECTED_LAMP,
      tcc_pkg::ST_REL:   cond = (q.cls == tcc_pkg::LN_POS);
      tcc_pkg::ST_RING:  cond = 1'b1;
      default:           cond = (q.cls == tcc_pkg::LN_NEG);
    endcase
    n.tcnt = cond ? q.tcnt + 25'h1 : 25'h0;
    hold = (q.st == tcc_pkg::ST_IDLE) ? q.s2[tcc_pkg::IN_OFF] : q.s2[tcc_pkg::IN_REL];
    n.hcnt = hold ? q.hcnt + 18'h1 : 18'h0;

    unique case (q.st)
      tcc_pkg::ST_IDLE: begin
        // incoming call after the connect latch delay.
        if (q.tcnt >= 25'(CONNECTED_LAMP_CYC - 1)) begin
          n.st = tcc_pkg::ST_CONNECTED_LAMP;
        // offline button held through the local latch delay.
        end else if (q.hcnt >= 18'(LOCL_CYC - 1)) begin
          n.st = tcc_pkg::ST_LOCAL;
        end else if (q.s2[tcc_pkg::IN_ORIG]) begin
          n.st = tcc_pkg::ST_ORIG;
        end
      end
      tcc_pkg::ST_ORIG: begin
        // interruption ended by current return latches the shunt.
        // only an interruption inside the accepted window qualifies.
        if (q.cls == tcc_pkg::LN_POS && q.tcnt >= 25'(PMIN_CYC - 1 - FILT_CYC) &&
            q.tcnt <= 25'(PMAX_CYC)) begin
          n.st = tcc_pkg::ST_DIAL;
        end else if (!q.s2[tcc_pkg::IN_ORIG]) begin
          n.st = tcc_pkg::ST_IDLE;
        end
      end
      tcc_pkg::ST_DIAL: begin
        // reversal held through the connect latch delay connects.
        if (q.tcnt >= 25'(CONNECTED_LAMP_CYC - 1)) begin
          n.st = tcc_pkg::ST_CONNECTED_LAMP;
        end else if (q.s2[tcc_pkg::IN_REL]) begin
          n.st = tcc_pkg::ST_REL;
        end
      end
      tcc_pkg::ST_CONNECTED_LAMP: begin
        // positive current ends a busy or far-released call.
        // far disconnect is handled as a local one.
        if (q.tcnt >= 25'(CONNECTED_LAMP_CYC - 1)) begin
          n.st = tcc_pkg::ST_IDLE;
        end else if (q.s2[tcc_pkg::IN_REL]) begin
          n.st = tcc_pkg::ST_REL;
        end
      end
      tcc_pkg::ST_REL: begin
        // exchange restores positive current to end the call.
        if (q.tcnt >= 25'(CONNECTED_LAMP_CYC - 1)) begin
          n.st = tcc_pkg::ST_IDLE;
        end
      end
      tcc_pkg::ST_LOCAL: begin
        // a call in local mode rings first.
        if (q.tcnt >= 25'(CONNECTED_LAMP_CYC - 1)) begin
          n.st = tcc_pkg::ST_RING;
        // leave local mode by release or originate.
        end else if (q.hcnt >= 18'(LOCL_CYC - 1)) begin
          n.st = tcc_pkg::ST_IDLE;
        end else if (q.s2[tcc_pkg::IN_ORIG]) begin
          n.st = tcc_pkg::ST_ORIG;
        end
      end
      tcc_pkg::ST_RING: begin
        // buzzer time elapsed, shift to connected.
        if (q.tcnt >= 25'(RING_CYC - 1)) begin
          n.st = tcc_pkg::ST_CONNECTED_LAMP;
        end
      end
      default: n.st = tcc_pkg::ST_IDLE;
    endcase
    if (n.st != q.st) begin
      n.tcnt = 25'h0;
      n.hcnt = 18'h0;
    end

    // Register slave: one wait state, ack drops the cycle after it is given.
    req = wb_cyc_i && wb_stb_i && !q.ack;
    n.ack = req;
    n.dat = 32'h0;
    if (req && !wb_we_i) begin
      if (wb_adr_i == tcc_pkg::ADR_STATUS) begin
        n.dat[tcc_pkg::ST_STATE_LSB +: 3] = q.st;
        n.dat[tcc_pkg::ST_CLASS_LSB +: 2] = q.cls;
        n.dat[tcc_pkg::ST_BUSY_BIT]       = (q.dleft != 4'h0);
        n.dat[tcc_pkg::ST_LEFT_LSB +: 4]  = q.dleft;
        n.dat[tcc_pkg::ST_MOTOR_BIT]      = q.motor;
      end else if (wb_adr_i == tcc_pkg::ADR_DIAL) begin
        n.dat[3:0] = q.dleft;
      end
    end

    // dial pulses at ten per second with 60 ms open.
    // each interval is 60 ms open then 40 ms closed.
    if (q.dleft != 4'h0) begin
      if (q.dcnt == 20'(DPER_CYC - 1)) begin
        n.dcnt = 20'h0;
        n.dleft = q.dleft - 4'h1;
      end else begin
        n.dcnt = q.dcnt + 20'h1;
      end
    end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == tcc_pkg::ADR_DIAL &&
                 (q.st == tcc_pkg::ST_DIAL || q.st == tcc_pkg::ST_CONNECTED_LAMP)) begin
      // A write while a digit is running is dropped, so digits never merge.
      digit = wb_dat_i[3:0];
      n.dleft = (digit == 4'h0 || digit > tcc_pkg::DIGIT_TEN) ? tcc_pkg::DIGIT_TEN : digit;
      n.dcnt = 20'h0;
    end
    // A call that ends mid-digit drops the rest, so an idle loop is never opened.
    if (n.st == tcc_pkg::ST_IDLE) begin
      n.dleft = 4'h0;
    end
    n.dial_open = (n.dleft != 4'h0) && (n.dcnt < 20'(DOPN_CYC));

    // motor runs on for the delay after the stop command.
    mcmd = (n.st == tcc_pkg::ST_CONNECTED_LAMP) || (n.st == tcc_pkg::ST_REL) ||
           (n.st == tcc_pkg::ST_LOCAL) || (n.st == tcc_pkg::ST_RING);
    if (mcmd) begin
      n.motor = 1'b1;
      n.mcnt = 23'h0;
    end else if (q.motor) begin
      if (q.mcnt == 23'(MOTR_CYC - 1)) begin
        n.motor = 1'b0;
      end
      n.mcnt = q.mcnt + 23'h1;
    end

    // idle leaves lamps dark and loop unshunted.
    // shunt is on in the originate, dial and connected states only, off in release, local and ring.
    n.shunt = (n.st == tcc_pkg::ST_ORIG) || (n.st == tcc_pkg::ST_DIAL) || (n.st == tcc_pkg::ST_CONNECTED_LAMP);
    // in connection space opens the loop, mark keeps full current.
    // release opens the loop only while held, so restored current can be seen.
    // Keying is ignored while a digit runs, so dial pulses are never lengthened.
    n.lopen = n.dial_open || (n.st == tcc_pkg::ST_REL && q.s2[tcc_pkg::IN_REL]) ||
              (n.st == tcc_pkg::ST_CONNECTED_LAMP && n.dleft == 4'h0 && !q.s2[tcc_pkg::IN_TX]);
    n.dlamp = (n.st == tcc_pkg::ST_DIAL);
    n.clamp = (n.st == tcc_pkg::ST_CONNECTED_LAMP);
    n.llamp = (n.st == tcc_pkg::ST_LOCAL);
    n.buzz = (n.st == tcc_pkg::ST_RING);
    // dialing blinds the selector with steady mark.
    // line decision uses the half-current comparator.
    if (n.dleft != 4'h0) begin
      n.magnet = 1'b1;
    end else if (n.st == tcc_pkg::ST_CONNECTED_LAMP || n.st == tcc_pkg::ST_REL) begin
      n.magnet = q.s2[tcc_pkg::IN_HALF];
    end else if (n.st == tcc_pkg::ST_LOCAL || n.st == tcc_pkg::ST_RING) begin
      n.magnet = q.s2[tcc_pkg::IN_TX];
    end else begin
      n.magnet = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign wb_ack_o         = q.ack;
  assign wb_dat_o         = q.dat;
  assign loop_shunt       = q.shunt;
  assign loop_open        = q.lopen;
  assign dial_lamp        = q.dlamp;
  assign connected_lamp   = q.clamp;
  assign local_lamp       = q.llamp;
  assign buzzer           = q.buzz;
  assign motor_on         = q.motor;
  assign magnet_amplifier = q.magnet;

  a_idle_dark: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == tcc_pkg::ST_IDLE |-> !dial_lamp && !connected_lamp && !local_lamp && !loop_shunt && !loop_open)
    else $error("idle state shows a lamp or loop change");

  a_orig_shunt: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == tcc_pkg::ST_ORIG |-> loop_shunt && !dial_lamp)
    else $error("originate state without shunt");

  a_dial_entry: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(dial_lamp) |-> $past(q.st) == tcc_pkg::ST_ORIG && $past(q.cls) == tcc_pkg::LN_POS && loop_shunt)
    else $error("proceed lamp lit without an interruption");

  a_pulse_open: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(q.dial_open) && q.dleft != 4'h0 |-> $past(q.dcnt) == 20'(DOPN_CYC - 1))
    else $error("dial pulse open time wrong");

  a_dial_blind: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.dleft != 4'h0 |-> magnet_amplifier && (loop_open == q.dial_open || q.st == tcc_pkg::ST_REL))
    else $error("selector not blinded while dialing");

  a_connected_lamp_motor: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $rose(connected_lamp) |-> motor_on && loop_shunt && $past(q.cls) == tcc_pkg::LN_NEG ||
    $past(q.st) == tcc_pkg::ST_RING)
    else $error("connect without negative current");

  a_ring_len: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(buzzer) && q.st == tcc_pkg::ST_CONNECTED_LAMP |-> $past(q.tcnt) == 25'(RING_CYC - 1))
    else $error("buzzer interval wrong");

  a_motor_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    $fell(motor_on) |-> $past(q.mcnt) == 23'(MOTR_CYC - 1))
    else $error("motor stopped before its delay");

  a_rel_idle: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.st == tcc_pkg::ST_REL ##1 q.st == tcc_pkg::ST_IDLE |-> $past(q.cls) == tcc_pkg::LN_POS && !connected_lamp)
    else $error("release ended without positive current");

  a_filter_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
    q.cls != $past(q.cls) |-> $past(q.fcnt) == 14'(FILT_CYC - 1))
    else $error("line class changed without filter time");
endmodule

/* File: logic/tcc_pkg.sv */
// Purpose: Shared constants for the telegraph call-control sequencer.
// Assumes: A 10 MHz system clock; times are held in microseconds.
// Notes:   Cycle counts are derived in the top module from these times.
package tcc_pkg;
  localparam int CLK_MHZ = 10;

  // Interval lengths in microseconds.
  localparam int T_FILT_US     = 1000;
  localparam int T_CONNECTED_LAMP_US     = 20000;
  localparam int T_LOCAL_US    = 20000;
  localparam int T_PTD_MIN_US  = 5000;
  localparam int T_PTD_MAX_US  = 50000;
  localparam int T_DIAL_OPN_US = 60000;
  localparam int T_DIAL_PER_US = 100000;
  localparam int T_RING_US     = 2600000;
  localparam int T_MOTOR_US    = 575000;

  // Register byte offsets.
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_DIAL   = 8'h04;

  // Status register field positions.
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CLASS_LSB = 4;
  localparam int ST_BUSY_BIT  = 8;
  localparam int ST_LEFT_LSB  = 9;
  localparam int ST_MOTOR_BIT = 16;

  // Digit code zero stands for ten pulses.
  localparam logic [3:0] DIGIT_TEN = 4'ha;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ORIG  = 3'h1,
    ST_DIAL  = 3'h2,
    ST_CONNECTED_LAMP  = 3'h3,
    ST_REL   = 3'h4,
    ST_LOCAL = 3'h5,
    ST_RING  = 3'h6
  } tcc_state_e;

  typedef enum logic [1:0] {
    LN_OPEN = 2'h0,
    LN_POS  = 2'h1,
    LN_NEG  = 2'h2
  } tcc_line_e;

  // Synchroniser bit positions.
  localparam int IN_POS  = 0;
  localparam int IN_NEG  = 1;
  localparam int IN_HALF = 2;
  localparam int IN_TX   = 3;
  localparam int IN_ORIG = 4;
  localparam int IN_REL  = 5;
  localparam int IN_OFF  = 6;
endpackage

/* File: tb/tcc_call_control_test.sv */
// Purpose: Self-checking bench for the call-control sequencer.
// Assumes: Short count parameters; the exchange model drives the loop levels.
// Notes:   Waits carry a few cycles of margin over sync and filter delay.
`timescale 1ns/1ps
module tcc_call_control_test;
  localparam int FILT = 4;
  localparam int CONNECTED_LAMP = 40;
  localparam int DOPN = 6;
  localparam int DPER = 10;
  localparam int RING = 100;
  logic        sys_clk    = 1'b0;
  logic        arst_n     = 1'b0;
  logic        neg_req    = 1'b0;
  logic        gap_req    = 1'b0;
  logic        tx_mark    = 1'b1;
  logic        orig_btn   = 1'b0;
  logic        rel_btn    = 1'b0;
  logic        off_btn    = 1'b0;
  logic        wb_cyc     = 1'b0;
  logic        wb_stb     = 1'b0;
  logic        wb_we      = 1'b0;
  logic [7:0]  wb_adr     = 8'h00;
  logic [31:0] wb_dat     = 32'h0;
  logic        line_pos, line_neg, line_half, wb_ack_o, loop_shunt, loop_open;
  logic        dial_lamp, connected_lamp, local_lamp, buzzer, motor_on, magnet_amplifier;
  logic [31:0] wb_dat_o;
  logic [31:0] rd_q;
  logic [3:0]  dig [3] = '{4'h1, 4'h0, 4'hb};
  int          np [3]  = '{1, 10, 10};
  int          opens, open_len, n0;
  int          fails       = 0;
  int          comparisons = 0;
  int          cyc_cnt     = 0;

  always #50 sys_clk = ~sys_clk;

  tcc_call_control #(.FILT_CYC(FILT), .CONNECTED_LAMP_CYC(CONNECTED_LAMP), .LOCL_CYC(40), .PMIN_CYC(20), .PMAX_CYC(200),
    .DOPN_CYC(DOPN), .DPER_CYC(DPER), .RING_CYC(RING), .MOTR_CYC(50)) i_tcc_call_control (
    .sys_clk(sys_clk), .arst_n(arst_n), .line_pos(line_pos), .line_neg(line_neg), .line_half(line_half),
    .tx_mark(tx_mark), .originate_button(orig_btn), .release_button(rel_btn), .offline_button(off_btn),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_dat), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .loop_shunt(loop_shunt),
    .loop_open(loop_open), .dial_lamp(dial_lamp), .connected_lamp(connected_lamp),
    .local_lamp(local_lamp), .buzzer(buzzer), .motor_on(motor_on), .magnet_amplifier(magnet_amplifier));

  tcc_exchange i_tcc_exchange (.sys_clk(sys_clk), .loop_shunt(loop_shunt), .loop_open(loop_open),
    .neg_req(neg_req), .gap_req(gap_req), .line_pos(line_pos), .line_neg(line_neg),
    .line_half(line_half), .opens(opens), .open_len(open_len));

  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Single classic cycle; the wait is bounded so a dead slave cannot hang the run.
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int t;
    t = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= adr;
    wb_dat <= dat;
    do begin
      @(posedge sys_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    rd_q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (t >= 20) chk("ack", 1, 0);
    @(posedge sys_clk);
  endtask

  task automatic st(input tcc_pkg::tcc_state_e exp);
    wb(1'b0, tcc_pkg::ADR_STATUS, 32'h0);
    chk("state", 32'(exp), 32'(rd_q[tcc_pkg::ST_STATE_LSB +: 3]));
  endtask

  task automatic gap(input int n);
    gap_req <= 1'b1;
    cyc(n);
    gap_req <= 1'b0;
    cyc(25);
  endtask

  always @(posedge sys_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      fails++;
      end_of_test();
    end
  end

  initial begin
    cyc(12);
    chk("outputs in reset", 0, {magnet_amplifier, loop_shunt, loop_open, motor_on});
    arst_n <= 1'b1;
    cyc(20);
    chk("idle outputs", 32'h100, {magnet_amplifier, loop_shunt, loop_open, dial_lamp, connected_lamp,
      local_lamp, buzzer, motor_on, 1'b0});
    st(tcc_pkg::ST_IDLE);
    chk("line class", 32'(tcc_pkg::LN_POS), 32'(rd_q[tcc_pkg::ST_CLASS_LSB +: 2]));
    wb(1'b0, 8'h08, 32'h0);
    chk("unmapped read", 0, rd_q);
    neg_req <= 1'b1;
    cyc(2);
    neg_req <= 1'b0;
    cyc(50);
    st(tcc_pkg::ST_IDLE);
    orig_btn <= 1'b1;
    cyc(10);
    chk("shunt", 1, loop_shunt);
    gap(8);
    chk("dial lamp short gap", 0, dial_lamp);
    gap(30);
    orig_btn <= 1'b0;
    cyc(10);
    chk("dial lamp", 1, {dial_lamp, loop_shunt} == 2'b11);
    st(tcc_pkg::ST_DIAL);
    for (int i = 0; i < 3; i++) begin
      n0 = opens;
      wb(1'b1, tcc_pkg::ADR_DIAL, {28'h0, dig[i]});
      wb(1'b1, tcc_pkg::ADR_DIAL, 32'h5);
      chk("magnet while dialing", 1, magnet_amplifier);
      wb(1'b0, tcc_pkg::ADR_STATUS, 32'h0);
      chk("busy", 1, rd_q[tcc_pkg::ST_BUSY_BIT]);
      cyc(np[i] * DPER + 10);
      chk("pulse count", np[i], opens - n0);
      chk("open length", DOPN, open_len);
    end
    neg_req <= 1'b1;
    cyc(60);
    chk("connect", 2'b11, {connected_lamp, motor_on});
    tx_mark <= 1'b0;
    cyc(8);
    chk("space", 2'b10, {loop_open, magnet_amplifier});
    tx_mark <= 1'b1;
    cyc(8);
    chk("mark", 2'b01, {loop_open, magnet_amplifier});
    n0 = opens;
    tx_mark <= 1'b0;
    wb(1'b1, tcc_pkg::ADR_DIAL, 32'h2);
    chk("magnet dialing connected", 1, magnet_amplifier);
    cyc(2 * DPER + 2);
    chk("connected pulse count", 2, opens - n0);
    chk("connected open length", DOPN, open_len);
    tx_mark <= 1'b1;
    cyc(8);
    rel_btn <= 1'b1;
    cyc(10);
    chk("release opens", 1, loop_open);
    st(tcc_pkg::ST_REL);
    rel_btn <= 1'b0;
    neg_req <= 1'b0;
    cyc(60);
    chk("release done", 2'b01, {connected_lamp, motor_on});
    cyc(50);
    chk("motor stopped", 0, motor_on);
    neg_req <= 1'b1;
    cyc(60);
    chk("incoming", 3'b111, {connected_lamp, motor_on, loop_shunt});
    gap(30);
    neg_req <= 1'b0;
    cyc(60);
    st(tcc_pkg::ST_IDLE);
    off_btn <= 1'b1;
    cyc(60);
    off_btn <= 1'b0;
    chk("local lamp", 1, local_lamp);
    neg_req <= 1'b1;
    cyc(60);
    chk("buzzer", 1, buzzer);
    cyc(RING + 10);
    chk("ring over", 2'b01, {buzzer, connected_lamp});
    neg_req <= 1'b0;
    cyc(60);
    off_btn <= 1'b1;
    cyc(60);
    off_btn <= 1'b0;
    rel_btn <= 1'b1;
    cyc(60);
    rel_btn <= 1'b0;
    chk("local exit", 0, local_lamp);
    off_btn <= 1'b1;
    cyc(60);
    off_btn <= 1'b0;
    orig_btn <= 1'b1;
    cyc(10);
    st(tcc_pkg::ST_ORIG);
    gap(30);
    orig_btn <= 1'b0;
    neg_req <= 1'b1;
    cyc(50);
    neg_req <= 1'b0;
    cyc(60);
    st(tcc_pkg::ST_IDLE);
    end_of_test();
  end
endmodule

/* File: tb/tcc_exchange.sv */
// Purpose: Exchange end of the loop, seen by the block as comparator levels.
// Assumes: The bench picks polarity and interruptions; the block opens the loop.
// Notes:   Counts loop openings and their length so dial pulses can be judged.
`timescale 1ns/1ps
module tcc_exchange (
  input  wire logic sys_clk,
  input  wire logic loop_shunt,
  input  wire logic loop_open,
  input  wire logic neg_req,
  input  wire logic gap_req,
  output logic      line_pos,
  output logic      line_neg,
  output logic      line_half,
  output int        opens,
  output int        open_len
);
  int   run   = 0;
  int   count = 0;
  int   len   = 0;
  logic flow;
  assign flow      = !loop_open && !gap_req;
  assign line_pos  = flow && !neg_req;
  assign line_neg  = flow && neg_req;
  assign line_half = flow && loop_shunt;
  assign opens     = count;
  assign open_len  = len;
  always @(posedge sys_clk) begin
    if (loop_open) begin
      run <= run + 1;
    end else if (run != 0) begin
      count <= count + 1;
      len   <= run;
      run   <= 0;
    end
  end
endmodule
